// ---- bench/jbs_host.sv ----
// tester model that drives the test port pins
`timescale 1ns/1ps
`default_nettype none
module jbs_host (
	output var jbs_pkg::jbs_jpins_t pins_out, // tck, tms, tdi
	input  wire logic               tdo_in,   // test data out
	input  wire logic               oe_n_in   // low while tdo driven
);
	import jbs_pkg::*;
	logic [127:0] cap; // bits seen on the last scan
	event         got; // scan finished
	// tdo line has a pull-up, so an undriven line reads high
	wire logic    tdo_w = oe_n_in ? 1'b1 : tdo_in;
	initial pins_out = '0;
	// one tck period; tck rests low between frames
	task step(input logic m, input logic d, output logic o);
		pins_out.tms = m;
		pins_out.tdi = d;
		#62.5 o = tdo_w;
		pins_out.tck = 1'b1;
		#62.5 pins_out.tck = 1'b0;
	endtask
	// tdi is not meaningful here, so it keeps toggling
	task idle(input logic m);
		logic o;
		step(m, ~pins_out.tdi, o);
	endtask
	// scan from idle back to idle, lsb first
	task scan(input logic ir, input int n, input logic [127:0] din);
		logic         o;
		logic [127:0] c;
		// build in c so the watcher still sees this scan while the next one runs
		c = '0;
		idle(1'b1);
		if (ir)
			idle(1'b1);
		idle(1'b0);
		idle(1'b0);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			c[i] = o;
		end
		idle(1'b1);
		idle(1'b0);
		cap = c;
		->got;
	endtask
endmodule
`default_nettype wire

// ---- bench/jtag_boundary_scan_tap_test.sv ----
// self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
module jtag_boundary_scan_tap_test;
	import jbs_pkg::*;
	localparam int N = 96;
	localparam logic [31:0] ID = {4'h5, 16'h0c3e, 11'h155, 1'b1};
	logic         mclk_in   = 1'b0;
	logic         rst_n_in  = 1'b0;
	logic         tap_en_in = 1'b1;
	logic [31:0]  uc        = '0;
	logic [15:0]  sig       = '0;
	logic [N-1:0] core      = '0;
	logic [N-1:0] pin       = '0;
	logic [N-1:0] pad;
	logic [31:0]  isp;
	logic         stb;
	logic         tdo;
	logic         oe_n;
	jbs_jpins_t   pins;
	jbs_jpins_t   upins;
	logic [127:0] exp_q[$];
	logic [127:0] r;
	logic [127:0] p;
	integer       seed         = 58892;
	int           fails        = 0;
	int           total_checks = 0;
	int           stb_cnt      = 0;

	jbs_host host (
		.pins_out (pins),
		.tdo_in   (tdo),
		.oe_n_in  (oe_n)
	);
	jbs_tap #(
		.BSR_LEN    (N),
		.ID_VERSION (4'h5),     // arbitrary value
		.ID_PART    (16'h0c3e), // arbitrary value
		.ID_MAKER   (11'h155)   // arbitrary value
	) dut (
		.mclk_in       (mclk_in),
		.rst_n_in      (rst_n_in),
		.tap_en_in     (tap_en_in),
		.jtag_pins_in  (pins),
		.usercode_in   (uc),
		.sig_in        (sig),
		.core_out_in   (core),
		.pin_in        (pin),
		.tdo_out       (tdo),
		.tdo_oe_n_out  (oe_n),
		.pad_out       (pad),
		.user_pins_out (upins),
		.isp_data_out  (isp),
		.isp_stb_out   (stb)
	);

	initial forever #5 mclk_in = ~mclk_in;

	task check(input string nm, input logic [127:0] seen, input logic [127:0] want);
		total_checks++;
		if (seen !== want)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task results();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// note the expected word, then run the scan
	task sc(input logic i, input int n, input logic [127:0] d, input logic [127:0] w);
		exp_q.push_back(w);
		host.scan(i, n, d);
	endtask
	task ins(input logic [9:0] c);
		sc(1'b1, IR_W, {118'h0, c}, 128'h001);
	endtask

	// every finished scan is compared with the oldest note
	always @(host.got)
		check("scan", host.cap, exp_q.pop_front());

	// every programming strobe is counted; one word must give exactly one
	always @(posedge mclk_in)
		if (stb)
			stb_cnt <= stb_cnt + 1;

	initial
	begin
		repeat (16) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		host.idle(1'b0);
		sc(1'b0, WORD_W, '0, ID);
		$display("test idcode done");
		// an unknown code must behave like bypass
		for (int k = 0; k < 2; k++)
		begin
			r = $random(seed);
			ins(k ? 10'h155 : IR_BYPASS);
			sc(1'b0, 8, r, {r[6:0], 1'b0});
		end
		$display("test bypass done");
		// five tms-high clocks park the controller, which reselects idcode
		repeat (5) host.idle(1'b1);
		host.idle(1'b0);
		sc(1'b0, WORD_W, '0, ID);
		$display("test controller reset done");
		@(posedge mclk_in);
		uc <= $random(seed);
		sig <= 16'($random(seed));
		ins(IR_USERCODE);
		sc(1'b0, WORD_W, '0, uc);
		ins(IR_SIGREAD);
		sc(1'b0, SIG_W, '0, sig);
		$display("test codes done");
		@(posedge mclk_in);
		pin <= {$random(seed), $random(seed), $random(seed)};
		core <= {$random(seed), $random(seed), $random(seed)};
		p = {$random(seed), $random(seed), $random(seed)};
		ins(IR_SAMPLE);
		sc(1'b0, N, p, pin);
		check("pad", pad, core);
		ins(IR_EXTEST);
		check("pad", pad, p);
		r = {$random(seed), $random(seed), $random(seed)};
		sc(1'b0, N, r, pin);
		check("pad", pad, r);
		$display("test boundary done");
		r = $random(seed);
		ins(IR_ISP_LOAD);
		sc(1'b0, WORD_W, {96'h0, r[31:0]}, '0);
		check("isp", isp, r[31:0]);
		check("strobe", stb_cnt, 128'h1);
		$display("test program done");
		@(posedge mclk_in);
		tap_en_in <= 1'b0;
		host.idle(1'b1);
		repeat (4) @(posedge mclk_in);
		#1;
		check("user", upins, host.pins_out);
		$display("test user pins done");
		results();
	end

	// the whole run needs well under this span
	initial
	begin
		#500000;
		fails++;
		results();
	end
endmodule
`default_nettype wire

// ---- logic/jbs_pkg.sv ----
// package: constants and types for the boundary-scan test access port
// Overview of operation
// - standard four-pin test port with boundary scan
// - test pins become user pins when disabled
// - SAMPLE captures pins, preloads boundary pattern
// - EXTEST drives boundary pattern, captures pin inputs
// - BYPASS puts one-stage register between TDI/TDO
// - IDCODE shifts identification word out TDO
// - USERCODE selects 32-bit user code register
// - signature read shifts 16-bit signature register
// - programming instruction (ISP load) accepted through test port
// - instruction register is exactly ten bits
// - boundary length 96, 192, 288, 480, 624
// - id word: version, part, maker, one
// - id word least significant bit is one
`default_nettype none
package jbs_pkg;
	localparam int IR_W   = 10;
	localparam int WORD_W = 32;
	localparam int SIG_W  = 16;
	localparam logic [9:0] IR_EXTEST   = 10'h000;
	localparam logic [9:0] IR_SAMPLE   = 10'h055;
	localparam logic [9:0] IR_IDCODE   = 10'h059;
	localparam logic [9:0] IR_USERCODE = 10'h007;
	localparam logic [9:0] IR_SIGREAD  = 10'h079;
	localparam logic [9:0] IR_ISP_LOAD = 10'h203;
	localparam logic [9:0] IR_BYPASS   = 10'h3ff;
	// fixed pattern loaded into the instruction shifter at Capture-IR
	localparam logic [9:0] IR_CAPTURE  = 10'h001;

	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} jbs_tap_t;

	typedef enum logic [2:0] {
		DR_BYP, DR_BSR, DR_ID, DR_UC, DR_SIG, DR_ISP
	} jbs_dr_t;

	typedef struct packed {
		logic [3:0]  version;
		logic [15:0] part;
		logic [10:0] maker;
		logic        one;
	} jbs_id_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jbs_jpins_t;
endpackage
`default_nettype wire

// ---- logic/jbs_tap.sv ----
// test access port, instruction decode and scan registers
`timescale 1ns/1ps
`default_nettype none
module jbs_tap #(
	parameter int          BSR_LEN    = 96,
	parameter logic [3:0]  ID_VERSION = 4'h2,     // arbitrary value
	parameter logic [15:0] ID_PART    = 16'h1234, // arbitrary value
	parameter logic [10:0] ID_MAKER   = 11'h0aa   // arbitrary value
) (
	input  wire logic               mclk_in,       // system clock
	input  wire logic               rst_n_in,      // async reset
	input  wire logic               tap_en_in,     // test port enabled
	input  wire jbs_pkg::jbs_jpins_t jtag_pins_in, // tck, tms, tdi pins
	input  wire logic [31:0]        usercode_in,   // programmed user code
	input  wire logic [15:0]        sig_in,        // user signature
	input  wire logic [BSR_LEN-1:0] core_out_in,   // core pin drive
	input  wire logic [BSR_LEN-1:0] pin_in,        // pad levels
	output logic                    tdo_out,       // test data out
	output logic                    tdo_oe_n_out,  // low drives tdo
	output logic [BSR_LEN-1:0]      pad_out,       // pad drive
	output jbs_pkg::jbs_jpins_t     user_pins_out, // pins as user inputs
	output logic [31:0]             isp_data_out,  // programming word
	output logic                    isp_stb_out    // programming word pulse
);
	import jbs_pkg::*;

	// refuse densities the device family does not build
	if (BSR_LEN != 96 && BSR_LEN != 192 && BSR_LEN != 288 &&
	    BSR_LEN != 480 && BSR_LEN != 624)
		$error("unsupported boundary length");

	localparam jbs_id_t ID_WORD = '{ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	typedef struct packed {
		jbs_jpins_t           s1;
		jbs_jpins_t           s2;
		jbs_jpins_t           s3;
		logic                 tck_lvl;
		jbs_tap_t             tap;
		logic [IR_W-1:0]      ir_sh;
		logic [IR_W-1:0]      ir;
		logic [BSR_LEN-1:0]   p1;
		logic [BSR_LEN-1:0]   p2;
		logic [BSR_LEN-1:0]   p3;
		logic [BSR_LEN-1:0]   pin_lvl;
		logic [BSR_LEN-1:0]   bsr_sh;
		logic [BSR_LEN-1:0]   bsr_upd;
		logic [WORD_W-1:0]    dr32;
		logic [SIG_W-1:0]     sig_sh;
		logic                 byp;
		logic                 tdo;
		logic                 tdo_oe_n;
		logic [BSR_LEN-1:0]   pad;
		jbs_jpins_t           upin;
		logic [WORD_W-1:0]    isp;
		logic                 isp_stb;
	} jbs_st_t;

	jbs_st_t q_reg;
	jbs_st_t q_next;
	logic    rise;
	logic    fall;
	jbs_dr_t sel;

	// standard sixteen-state controller steered by tms
	function automatic jbs_tap_t tap_next(input jbs_tap_t s, input logic m);
		case (s)
			TLR:     tap_next = m ? TLR : RTI;
			RTI:     tap_next = m ? SEL_DR : RTI;
			SEL_DR:  tap_next = m ? SEL_IR : CAP_DR;
			CAP_DR:  tap_next = m ? EX1_DR : SH_DR;
			SH_DR:   tap_next = m ? EX1_DR : SH_DR;
			EX1_DR:  tap_next = m ? UPD_DR : PAU_DR;
			PAU_DR:  tap_next = m ? EX2_DR : PAU_DR;
			EX2_DR:  tap_next = m ? UPD_DR : SH_DR;
			UPD_DR:  tap_next = m ? SEL_DR : RTI;
			SEL_IR:  tap_next = m ? TLR : CAP_IR;
			CAP_IR:  tap_next = m ? EX1_IR : SH_IR;
			SH_IR:   tap_next = m ? EX1_IR : SH_IR;
			EX1_IR:  tap_next = m ? UPD_IR : PAU_IR;
			PAU_IR:  tap_next = m ? EX2_IR : PAU_IR;
			EX2_IR:  tap_next = m ? UPD_IR : SH_IR;
			UPD_IR:  tap_next = m ? SEL_DR : RTI;
			default: tap_next = TLR;
		endcase
	endfunction

	// unknown codes fall back to bypass so a chain never breaks
	function automatic jbs_dr_t dr_of(input logic [IR_W-1:0] i);
		case (i)
			IR_EXTEST, IR_SAMPLE: dr_of = DR_BSR;
			IR_IDCODE:            dr_of = DR_ID;
			IR_USERCODE:          dr_of = DR_UC;
			IR_SIGREAD:           dr_of = DR_SIG;
			IR_ISP_LOAD:          dr_of = DR_ISP;
			default:              dr_of = DR_BYP;
		endcase
	endfunction

	// edges count only once the second and third stages agree
	assign rise = (q_reg.s2.tck == q_reg.s3.tck) && q_reg.s3.tck && !q_reg.tck_lvl;
	assign fall = (q_reg.s2.tck == q_reg.s3.tck) && !q_reg.s3.tck && q_reg.tck_lvl;
	assign sel  = dr_of(q_reg.ir);

	// next state of the whole port
	always_comb
	begin
		q_next         = q_reg;
		q_next.s1      = jtag_pins_in;
		q_next.s2      = q_reg.s1;
		q_next.s3      = q_reg.s2;
		q_next.p1      = pin_in;
		q_next.p2      = q_reg.p1;
		q_next.p3      = q_reg.p2;
		// a pad bit counts once two stages agree, else it keeps its level
		q_next.pin_lvl = (q_reg.p2 & q_reg.p3) | (q_reg.pin_lvl & (q_reg.p2 | q_reg.p3));
		q_next.isp_stb = 1'b0;
		if (q_reg.s2.tck == q_reg.s3.tck)
			q_next.tck_lvl = q_reg.s3.tck;
		// pads follow core unless EXTEST owns them
		q_next.pad = (q_reg.ir == IR_EXTEST) ? q_reg.bsr_upd : core_out_in;
		if (!tap_en_in)
		begin
			// pins serve the user design, port held in reset
			q_next.tap      = TLR;
			q_next.ir       = IR_IDCODE;
			q_next.tdo_oe_n = 1'b1;
			q_next.upin     = q_reg.s3;
		end
		else if (rise)
		begin
			// tms and tdi sampled on the rising edge
			case (q_reg.tap)
				TLR:
					q_next.ir = IR_IDCODE;
				CAP_DR:
					case (sel)
						DR_BSR:  q_next.bsr_sh = q_reg.pin_lvl;
						DR_ID:   q_next.dr32 = ID_WORD;
						DR_UC:   q_next.dr32 = usercode_in;
						DR_SIG:  q_next.sig_sh = sig_in;
						DR_ISP:  q_next.dr32 = q_reg.isp;
						default: q_next.byp = 1'b0;
					endcase
				SH_DR:
					case (sel)
						DR_BSR:  q_next.bsr_sh = {q_reg.s3.tdi, q_reg.bsr_sh[BSR_LEN-1:1]};
						DR_ID, DR_UC, DR_ISP:
							q_next.dr32 = {q_reg.s3.tdi, q_reg.dr32[WORD_W-1:1]};
						DR_SIG:  q_next.sig_sh = {q_reg.s3.tdi, q_reg.sig_sh[SIG_W-1:1]};
						default: q_next.byp = q_reg.s3.tdi;
					endcase
				UPD_DR:
					if (sel == DR_BSR)
						q_next.bsr_upd = q_reg.bsr_sh;
					else if (sel == DR_ISP)
					begin
						q_next.isp     = q_reg.dr32;
						q_next.isp_stb = 1'b1;
					end
				CAP_IR:
					q_next.ir_sh = IR_CAPTURE;
				SH_IR:
					q_next.ir_sh = {q_reg.s3.tdi, q_reg.ir_sh[IR_W-1:1]};
				UPD_IR:
					q_next.ir = q_reg.ir_sh;
				default:
					q_next.ir = q_reg.ir;
			endcase
			q_next.tap = tap_next(q_reg.tap, q_reg.s3.tms);
		end
		else if (fall)
		begin
			// tdo moves only on the falling edge, a half period of margin
			q_next.tdo_oe_n = !(q_reg.tap == SH_DR || q_reg.tap == SH_IR);
			if (q_reg.tap == SH_IR)
				q_next.tdo = q_reg.ir_sh[0];
			else
				case (sel)
					DR_BSR:  q_next.tdo = q_reg.bsr_sh[0];
					DR_ID, DR_UC, DR_ISP:
						q_next.tdo = q_reg.dr32[0];
					DR_SIG:  q_next.tdo = q_reg.sig_sh[0];
					default: q_next.tdo = q_reg.byp;
				endcase
		end
	end

	// state register; idcode selected and tdo released at reset
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			q_reg          <= '0;
			q_reg.ir       <= IR_IDCODE;
			q_reg.tdo_oe_n <= 1'b1;
		end
		else
			q_reg <= q_next;
	end

	// outputs come straight from the state register
	assign tdo_out       = q_reg.tdo;
	assign tdo_oe_n_out  = q_reg.tdo_oe_n;
	assign pad_out       = q_reg.pad;
	assign user_pins_out = q_reg.upin;
	assign isp_data_out  = q_reg.isp;
	assign isp_stb_out   = q_reg.isp_stb;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_step(jbs_tap_t st);
		tap_en_in && rise && q_reg.tap == st;
	endsequence
	sequence s_cap_dr(jbs_dr_t d);
		s_step(CAP_DR) ##0 sel == d;
	endsequence
	// update of a data register, the second half of every scan
	sequence s_update(jbs_dr_t d);
		s_step(UPD_DR) ##0 sel == d;
	endsequence
	// falling edge seen while the port is live
	sequence s_drop(jbs_tap_t st);
		tap_en_in && fall && q_reg.tap == st;
	endsequence

	AST_TLR_HOLD: assert property (s_step(TLR) ##0 q_reg.s3.tms |=> q_reg.tap == TLR)
		else $error("controller left reset with tms high");
	AST_IR_CAPTURE: assert property (s_step(CAP_IR) |=> q_reg.ir_sh == IR_CAPTURE)
		else $error("instruction capture pattern wrong");
	AST_ID_WORD: assert property (s_cap_dr(DR_ID) |=> q_reg.dr32 == ID_WORD)
		else $error("id word not loaded");
	AST_ID_LSB: assert property (s_cap_dr(DR_ID) |=> q_reg.dr32[0])
		else $error("id word lsb not one");
	AST_USERCODE: assert property (s_cap_dr(DR_UC) |=> q_reg.dr32 == $past(usercode_in))
		else $error("user code not captured");
	AST_SIG_SHIFT: assert property (s_step(SH_DR) ##0 sel == DR_SIG
		|=> q_reg.sig_sh[SIG_W-1] == $past(q_reg.s3.tdi))
		else $error("signature shift wrong");
	AST_BYPASS: assert property (s_step(SH_DR) ##0 sel == DR_BYP
		|=> q_reg.byp == $past(q_reg.s3.tdi))
		else $error("bypass stage wrong");
	AST_SAMPLE_CAP: assert property (s_step(CAP_DR) ##0 q_reg.ir == IR_SAMPLE
		|=> q_reg.bsr_sh == $past(q_reg.pin_lvl))
		else $error("pin snapshot not captured");
	AST_EXTEST_DRIVE: assert property (q_reg.ir == IR_EXTEST ##1 q_reg.ir == IR_EXTEST
		|-> q_reg.pad == $past(q_reg.bsr_upd))
		else $error("extest pattern not on pads");
	AST_UPD_ONLY: assert property ($changed(q_reg.bsr_upd)
		|-> $past(rise && q_reg.tap == UPD_DR))
		else $error("boundary outputs changed outside update");
	AST_TDO_FALL: assert property ($changed(q_reg.tdo) |-> $past(fall))
		else $error("tdo changed off the falling edge");
	AST_USER_MODE: assert property (!tap_en_in |=> q_reg.tap == TLR && q_reg.tdo_oe_n)
		else $error("port active while disabled");

	// controller and instruction register
	AST_TLR_IR: assert property (s_step(TLR) |=> q_reg.ir == IR_IDCODE)
		else $error("instruction not reset to idcode");
	AST_IR_SHIFT: assert property (s_step(SH_IR)
		|=> q_reg.ir_sh[IR_W-1] == $past(q_reg.s3.tdi))
		else $error("instruction shift wrong");
	AST_IR_UPDATE: assert property (s_step(UPD_IR) |=> q_reg.ir == $past(q_reg.ir_sh))
		else $error("instruction not latched at update");
	// the active instruction may only move at update, reset or while disabled
	AST_IR_HOLD: assert property ($changed(q_reg.ir)
		|-> $past(!tap_en_in || (rise && (q_reg.tap == UPD_IR || q_reg.tap == TLR))))
		else $error("instruction changed outside update");
	// data registers: capture and shift
	AST_BYP_CAP: assert property (s_cap_dr(DR_BYP) |=> !q_reg.byp)
		else $error("bypass stage did not capture zero");
	AST_SIG_CAP: assert property (s_cap_dr(DR_SIG) |=> q_reg.sig_sh == $past(sig_in))
		else $error("signature not captured");
	AST_EXTEST_CAP: assert property (s_step(CAP_DR) ##0 q_reg.ir == IR_EXTEST
		|=> q_reg.bsr_sh == $past(q_reg.pin_lvl))
		else $error("input pins not captured");
	AST_BSR_SHIFT: assert property (s_step(SH_DR) ##0 sel == DR_BSR
		|=> q_reg.bsr_sh == {$past(q_reg.s3.tdi), $past(q_reg.bsr_sh[BSR_LEN-1:1])})
		else $error("boundary shift wrong");
	AST_WORD_SHIFT: assert property (s_step(SH_DR) ##0 sel == DR_ID
		|=> q_reg.dr32 == {$past(q_reg.s3.tdi), $past(q_reg.dr32[WORD_W-1:1])})
		else $error("identification shift wrong");
	// boundary outputs reach the pads only through update
	AST_BSR_UPDATE: assert property (s_update(DR_BSR)
		|=> q_reg.bsr_upd == $past(q_reg.bsr_sh))
		else $error("boundary update latch not loaded");
	AST_PAD_CORE: assert property (q_reg.ir != IR_EXTEST |=> q_reg.pad == $past(core_out_in))
		else $error("pads left the core during normal operation");
	// programming word and its one-cycle strobe
	AST_ISP_WORD: assert property (s_update(DR_ISP)
		|=> q_reg.isp == $past(q_reg.dr32) && q_reg.isp_stb)
		else $error("programming word not handed over");
	AST_ISP_STB: assert property (q_reg.isp_stb
		|-> $past(rise && tap_en_in && q_reg.tap == UPD_DR && sel == DR_ISP))
		else $error("programming strobe without update");
	AST_STB_PULSE: assert property (q_reg.isp_stb |=> !q_reg.isp_stb)
		else $error("programming strobe longer than one cycle");
	// tdo is driven only around the shift states, from the selected shifter
	AST_TDO_OE: assert property (!q_reg.tdo_oe_n
		|-> q_reg.tap inside {SH_DR, SH_IR, EX1_DR, EX1_IR})
		else $error("tdo driven outside shift");
	AST_TDO_IR: assert property (s_drop(SH_IR)
		|=> q_reg.tdo == $past(q_reg.ir_sh[0]) && !q_reg.tdo_oe_n)
		else $error("instruction bit not on tdo");
	AST_TDO_DR: assert property (s_drop(SH_DR) ##0 sel == DR_SIG
		|=> q_reg.tdo == $past(q_reg.sig_sh[0]) && !q_reg.tdo_oe_n)
		else $error("signature bit not on tdo");
	AST_TDO_OFF: assert property (s_drop(EX1_DR) |=> q_reg.tdo_oe_n)
		else $error("tdo still driven after shift");
endmodule
`default_nettype wire
